// ===== ddrc_pkg.sv
// constants and types for the ddr command encoder block
package ddrc_pkg;
  // ===========================================================================
  // pin widths
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 14;
  localparam int BANK_W  = 3;
  localparam int MASK_W  = 2;
  localparam int CODE_W  = 4;
  localparam int AP_BIT  = 10;
  localparam int ENTRY_W = CODE_W + BANK_W + ADDR_W + DATA_W + MASK_W;
  localparam int FIFO_DEPTH = 8;
  // ===========================================================================
  // clock ratios
  localparam int BUS_DIV = 2;
  localparam int MEM_DIV = 2;
  // ===========================================================================
  // command codes on the request port
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_DESELECT   = 4'h1;
  localparam logic [3:0] CMD_ACTIVATE   = 4'h2;
  localparam logic [3:0] CMD_PRE_ALL    = 4'h3;
  localparam logic [3:0] CMD_PRE_ONE    = 4'h4;
  localparam logic [3:0] CMD_MODE_SET   = 4'h5;
  localparam logic [3:0] CMD_EXT_MODE   = 4'h6;
  localparam logic [3:0] CMD_READ       = 4'h7;
  localparam logic [3:0] CMD_READ_AP    = 4'h8;
  localparam logic [3:0] CMD_WRITE      = 4'h9;
  localparam logic [3:0] CMD_WRITE_AP   = 4'hA;
  localparam logic [3:0] CMD_AUTO_REF   = 4'hB;
  localparam logic [3:0] CMD_SREF_ENTER = 4'hC;
  localparam logic [3:0] CMD_SREF_EXIT  = 4'hD;
  localparam logic [3:0] CMD_PD_ENTER   = 4'hE;
  localparam logic [3:0] CMD_PD_EXIT    = 4'hF;
  // ===========================================================================
  // strobe patterns {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PAT_DESELECT = 4'hF;
  localparam logic [3:0] PAT_NOP      = 4'h7;
  localparam logic [3:0] PAT_ACTIVATE = 4'h3;
  localparam logic [3:0] PAT_PRECHG   = 4'h2;
  localparam logic [3:0] PAT_MODE     = 4'h0;
  localparam logic [3:0] PAT_READ     = 4'h5;
  localparam logic [3:0] PAT_WRITE    = 4'h4;
  localparam logic [3:0] PAT_REFRESH  = 4'h1;
  // ===========================================================================
  // reset values
  localparam logic       CKE_RESET    = 1'b0;
  localparam logic [1:0] SYNC_RESET   = 2'h0;
  typedef enum logic [2:0] {ddrc_idle_e, ddrc_issue_e, ddrc_wdata_e, ddrc_rgate_e, ddrc_done_e} ddrc_state_t;
endpackage

// ===== ddrc_top.sv
// ddr command encoder: request fifo, domain crossing, command and data pins
// Functional notes
// R1 - memory clock pair toggles at half the double-rate clock
// R2 - bus-side clock is primary pll divided by fixed two
// R3 - command fifo and request port run on the bus-side clock
// R4 - state machine runs on double-rate clock divided by two
// R5 - clocks may be stopped through a request and acknowledge procedure
// R6 - system keeps reset until secondary pll and double-rate clock are stable; code has no pll lock input, rst_n only passes a two-flop synchroniser
// R7 - 16-bit data, 14-bit address, three bank, one chip select, one clock enable
// R8 - clock enable active high; chip select and command strobes active low
// R9 - byte masks active high, masking write byte lanes
// R10 - data strobes driven with write data, received with read data
// R11 - strobe gate driven out, returned copy gates read strobes
// R12 - activate: cs low, ras low, cas high, we high, bank and row
// R13 - precharge all: precharge pattern with address bit 10 high
// R14 - single precharge: address bit 10 low, bank on bank pins
// R15 - mode sets: all strobes low, bank selects register, address carries code
// R16 - read: cs low, ras high, cas low, we high; bit 10 selects autoprecharge
// R17 - write: read pattern with we low; bit 10 selects autoprecharge
// R18 - refresh, self-refresh entry drops cke, exit raises cke with nop
// R19 - nop, deselect, power-down entry and exit by cke with nop
// R20 - requests cross from bus side to memory side through synchronised handshake
`timescale 1ns/1ps

// =============================================================================
// request fifo
module ddrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PW:0]      count_reg, count_next;
  logic             push, pop;

  assign in_ready  = (count_reg != DEPTH[PW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = en & in_valid & in_ready;
  assign pop       = en & out_valid & out_ready;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule // ddrc_fifo

// =============================================================================
// top
module ddrc_top (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic                         primary_pll_tick,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire logic [ddrc_pkg::CODE_W-1:0]  req_code,
  input  wire logic [ddrc_pkg::BANK_W-1:0]  req_bank,
  input  wire logic [ddrc_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [ddrc_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic [ddrc_pkg::MASK_W-1:0]  req_wmask,
  output logic                              rd_valid,
  output logic      [ddrc_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                         clk_stop_req,
  output logic                              clk_stop_ack,
  output logic                              ddr_clk_p,
  output logic                              ddr_clk_n,
  output logic                              ddr_cke,
  output logic                              ddr_cs_n,
  output logic                              ddr_ras_n,
  output logic                              ddr_cas_n,
  output logic                              ddr_we_n,
  output logic      [ddrc_pkg::BANK_W-1:0]  ddr_ba,
  output logic      [ddrc_pkg::ADDR_W-1:0]  ddr_a,
  output logic      [ddrc_pkg::MASK_W-1:0]  ddr_dm,
  output logic      [ddrc_pkg::DATA_W-1:0]  ddr_dq_o,
  output logic                              ddr_dq_oe,
  input  wire logic [ddrc_pkg::DATA_W-1:0]  ddr_dq_i,
  output logic      [ddrc_pkg::MASK_W-1:0]  ddr_dqs_o,
  output logic                              ddr_dqs_oe,
  input  wire logic [ddrc_pkg::MASK_W-1:0]  ddr_dqs_i,
  output logic                              strobe_gate_out,
  input  wire logic                         strobe_gate_return
);
  // ===========================================================================
  // reset release; rest of the block uses the synchronised copy
  logic [1:0] rst_sync_reg;
  logic       rst_n_int;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= ddrc_pkg::SYNC_RESET;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  // ===========================================================================
  // clock dividers and stop control
  logic bus_ph_reg, bus_ph_next, mem_ph_reg, mem_ph_next;
  logic stop_reg, stop_next;
  logic bus_ce, mem_ce;
  logic fifo_out_valid, fifo_out_ready;
  logic [ddrc_pkg::ENTRY_W-1:0] fifo_out_data;
  ddrc_pkg::ddrc_state_t state_reg, state_next;
  logic req_tog_reg, req_tog_next, ack_tog_reg, ack_tog_next;

  // bus strobe every second primary pll tick, no programmable divider
  assign bus_ce = ce & primary_pll_tick & bus_ph_reg; // [R2]
  // memory domain runs on every second double-rate edge
  assign mem_ce = ce & mem_ph_reg & ~stop_reg; // [R4]

  always_comb begin
    bus_ph_next = bus_ph_reg;
    mem_ph_next = mem_ph_reg;
    stop_next   = stop_reg;
    if (ce && primary_pll_tick) begin
      bus_ph_next = ~bus_ph_reg;
    end
    if (ce && !stop_reg) begin
      mem_ph_next = ~mem_ph_reg; // [R1]
    end
    // stop only once idle, drained and no handshake outstanding;
    // a stopped clock never returns to its low phase, so release is taken on any cycle
    if (ce && stop_reg) begin
      stop_next = clk_stop_req; // [R5]
    end else if (ce && !mem_ph_reg) begin
      stop_next = clk_stop_req & ~fifo_out_valid & (state_reg == ddrc_pkg::ddrc_idle_e) &
                  (req_tog_reg == ack_tog_reg); // [R5]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      bus_ph_reg <= 1'b0;
      mem_ph_reg <= 1'b0;
      stop_reg   <= 1'b0;
    end else begin
      bus_ph_reg <= bus_ph_next;
      mem_ph_reg <= mem_ph_next;
      stop_reg   <= stop_next;
    end
  end

  // memory clock pair parks high/low while stopped
  assign ddr_clk_p    = mem_ph_reg; // [R1]
  assign ddr_clk_n    = ~mem_ph_reg;
  assign clk_stop_ack = stop_reg;

  // ===========================================================================
  // bus-side fifo and handshake sender
  ddrc_fifo #(
    .WIDTH (ddrc_pkg::ENTRY_W),
    .DEPTH (ddrc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n_int),
    .en        (bus_ce), // [R3]
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_code, req_bank, req_addr, req_wdata, req_wmask}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  logic [ddrc_pkg::ENTRY_W-1:0] hold_reg, hold_next;
  logic [1:0] ack_sync_reg, req_sync_reg;

  // only one request in flight; hold stays stable until acknowledged
  assign fifo_out_ready = (req_tog_reg == ack_sync_reg[1]) & ~stop_reg; // [R20]

  always_comb begin
    hold_next    = hold_reg;
    req_tog_next = req_tog_reg;
    if (bus_ce && fifo_out_valid && fifo_out_ready) begin
      hold_next    = fifo_out_data;
      req_tog_next = ~req_tog_reg; // [R20]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      hold_reg     <= '0;
      req_tog_reg  <= 1'b0;
      ack_sync_reg <= ddrc_pkg::SYNC_RESET;
      req_sync_reg <= ddrc_pkg::SYNC_RESET;
    end else begin
      hold_reg     <= hold_next;
      req_tog_reg  <= req_tog_next;
      if (ce) begin
        ack_sync_reg <= {ack_sync_reg[0], ack_tog_reg}; // [R20]
        req_sync_reg <= {req_sync_reg[0], req_tog_reg}; // [R20]
      end
    end
  end

  // ===========================================================================
  // memory-side command encoder
  logic [ddrc_pkg::CODE_W-1:0] h_code;
  logic [ddrc_pkg::BANK_W-1:0] h_bank;
  logic [ddrc_pkg::ADDR_W-1:0] h_addr;
  logic [ddrc_pkg::DATA_W-1:0] h_wdata;
  logic [ddrc_pkg::MASK_W-1:0] h_wmask;
  assign {h_code, h_bank, h_addr, h_wdata, h_wmask} = hold_reg;

  logic [3:0] pat_reg, pat_next;
  logic       cke_reg, cke_next;
  logic [ddrc_pkg::BANK_W-1:0] ba_reg, ba_next;
  logic [ddrc_pkg::ADDR_W-1:0] a_reg, a_next;
  logic [ddrc_pkg::DATA_W-1:0] dq_reg, dq_next, rd_data_reg, rd_data_next;
  logic [ddrc_pkg::MASK_W-1:0] dm_reg, dm_next, dqs_reg, dqs_next;
  logic dq_oe_reg, dq_oe_next, gate_reg, gate_next, rd_valid_reg, rd_valid_next;

  always_comb begin
    state_next    = state_reg;
    ack_tog_next  = ack_tog_reg;
    pat_next      = pat_reg;
    cke_next      = cke_reg;
    ba_next       = ba_reg;
    a_next        = a_reg;
    dq_next       = dq_reg;
    dm_next       = dm_reg;
    dqs_next      = dqs_reg;
    dq_oe_next    = dq_oe_reg;
    gate_next     = gate_reg;
    rd_data_next  = rd_data_reg;
    rd_valid_next = ce ? 1'b0 : rd_valid_reg;
    // returned gate qualifies incoming strobes before data is taken
    if (ce && strobe_gate_return && (ddr_dqs_i != '0)) begin // [R11]
      rd_data_next  = ddr_dq_i; // [R10]
      rd_valid_next = 1'b1;
    end
    if (mem_ce) begin
      case (state_reg)
        ddrc_pkg::ddrc_idle_e: begin
          pat_next   = ddrc_pkg::PAT_DESELECT; // [R19]
          dq_oe_next = 1'b0;
          gate_next  = 1'b0;
          if (req_sync_reg[1] != ack_tog_reg) begin
            state_next = ddrc_pkg::ddrc_issue_e; // [R20]
          end
        end
        ddrc_pkg::ddrc_issue_e: begin
          ba_next    = h_bank;
          a_next     = h_addr;
          state_next = ddrc_pkg::ddrc_done_e;
          case (h_code)
            ddrc_pkg::CMD_NOP:      pat_next = ddrc_pkg::PAT_NOP; // [R19]
            ddrc_pkg::CMD_DESELECT: pat_next = ddrc_pkg::PAT_DESELECT; // [R19]
            ddrc_pkg::CMD_ACTIVATE: pat_next = ddrc_pkg::PAT_ACTIVATE; // [R12]
            ddrc_pkg::CMD_PRE_ALL: begin
              pat_next = ddrc_pkg::PAT_PRECHG;
              a_next[ddrc_pkg::AP_BIT] = 1'b1; // [R13]
            end
            ddrc_pkg::CMD_PRE_ONE: begin
              pat_next = ddrc_pkg::PAT_PRECHG;
              a_next[ddrc_pkg::AP_BIT] = 1'b0; // [R14]
            end
            ddrc_pkg::CMD_MODE_SET,
            ddrc_pkg::CMD_EXT_MODE: pat_next = ddrc_pkg::PAT_MODE; // [R15]
            ddrc_pkg::CMD_READ,
            ddrc_pkg::CMD_READ_AP: begin
              pat_next = ddrc_pkg::PAT_READ;
              a_next[ddrc_pkg::AP_BIT] = (h_code == ddrc_pkg::CMD_READ_AP); // [R16]
              state_next = ddrc_pkg::ddrc_rgate_e;
            end
            ddrc_pkg::CMD_WRITE,
            ddrc_pkg::CMD_WRITE_AP: begin
              pat_next = ddrc_pkg::PAT_WRITE;
              a_next[ddrc_pkg::AP_BIT] = (h_code == ddrc_pkg::CMD_WRITE_AP); // [R17]
              state_next = ddrc_pkg::ddrc_wdata_e;
            end
            ddrc_pkg::CMD_AUTO_REF: begin
              pat_next = ddrc_pkg::PAT_REFRESH;
              cke_next = 1'b1; // [R18]
            end
            ddrc_pkg::CMD_SREF_ENTER: begin
              pat_next = ddrc_pkg::PAT_REFRESH;
              cke_next = 1'b0; // [R18]
            end
            ddrc_pkg::CMD_SREF_EXIT,
            ddrc_pkg::CMD_PD_EXIT: begin
              pat_next = ddrc_pkg::PAT_NOP;
              cke_next = 1'b1; // [R18] [R19]
            end
            ddrc_pkg::CMD_PD_ENTER: begin
              pat_next = ddrc_pkg::PAT_NOP;
              cke_next = 1'b0; // [R19]
            end
            default: pat_next = ddrc_pkg::PAT_NOP;
          endcase
        end
        ddrc_pkg::ddrc_wdata_e: begin
          // write data, masks and strobes go out together
          pat_next   = ddrc_pkg::PAT_NOP;
          dq_next    = h_wdata;
          dm_next    = h_wmask; // [R9]
          dqs_next   = '1;
          dq_oe_next = 1'b1; // [R10]
          state_next = ddrc_pkg::ddrc_done_e;
        end
        ddrc_pkg::ddrc_rgate_e: begin
          pat_next   = ddrc_pkg::PAT_NOP;
          gate_next  = 1'b1; // [R11]
          state_next = ddrc_pkg::ddrc_done_e;
        end
        ddrc_pkg::ddrc_done_e: begin
          pat_next     = ddrc_pkg::PAT_DESELECT;
          dq_oe_next   = 1'b0;
          dqs_next     = '0;
          dm_next      = '0;
          gate_next    = 1'b0;
          ack_tog_next = ~ack_tog_reg; // [R20]
          state_next   = ddrc_pkg::ddrc_idle_e;
        end
        default: state_next = ddrc_pkg::ddrc_idle_e;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_reg    <= ddrc_pkg::ddrc_idle_e;
      ack_tog_reg  <= 1'b0;
      pat_reg      <= ddrc_pkg::PAT_DESELECT;
      cke_reg      <= ddrc_pkg::CKE_RESET;
      ba_reg       <= '0;
      a_reg        <= '0;
      dq_reg       <= '0;
      dm_reg       <= '0;
      dqs_reg      <= '0;
      dq_oe_reg    <= 1'b0;
      gate_reg     <= 1'b0;
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ack_tog_reg  <= ack_tog_next;
      pat_reg      <= pat_next;
      cke_reg      <= cke_next;
      ba_reg       <= ba_next;
      a_reg        <= a_next;
      dq_reg       <= dq_next;
      dm_reg       <= dm_next;
      dqs_reg      <= dqs_next;
      dq_oe_reg    <= dq_oe_next;
      gate_reg     <= gate_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // ===========================================================================
  // pins
  assign {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} = pat_reg; // [R8]
  assign ddr_cke         = cke_reg; // [R8]
  assign ddr_ba          = ba_reg; // [R7]
  assign ddr_a           = a_reg;
  assign ddr_dm          = dm_reg;
  assign ddr_dq_o        = dq_reg;
  assign ddr_dq_oe       = dq_oe_reg;
  assign ddr_dqs_o       = dqs_reg;
  assign ddr_dqs_oe      = dq_oe_reg; // [R10]
  assign strobe_gate_out = gate_reg;
  assign rd_data         = rd_data_reg;
  assign rd_valid        = rd_valid_reg;
endmodule // ddrc_top

// ===== ddrc_top_props.sv
// checker for the ddr command encoder pins
`timescale 1ns/1ps
module ddrc_chk (
  input wire logic                        core_clk,
  input wire logic                        rst_n,
  input wire logic                        ce,
  input wire logic                        clk_stop_req,
  input wire logic                        clk_stop_ack,
  input wire logic                        ddr_clk_p,
  input wire logic                        ddr_clk_n,
  input wire logic                        ddr_cke,
  input wire logic                        ddr_cs_n,
  input wire logic                        ddr_ras_n,
  input wire logic                        ddr_cas_n,
  input wire logic                        ddr_we_n,
  input wire logic [ddrc_pkg::BANK_W-1:0] ddr_ba,
  input wire logic [ddrc_pkg::ADDR_W-1:0] ddr_a,
  input wire logic                        ddr_dq_oe,
  input wire logic [ddrc_pkg::MASK_W-1:0] ddr_dqs_o,
  input wire logic                        ddr_dqs_oe,
  input wire logic [ddrc_pkg::DATA_W-1:0] ddr_dq_i,
  input wire logic [ddrc_pkg::MASK_W-1:0] ddr_dqs_i,
  input wire logic                        strobe_gate_out,
  input wire logic                        strobe_gate_return,
  input wire logic                        rd_valid,
  input wire logic [ddrc_pkg::DATA_W-1:0] rd_data
);
  logic [3:0] cmd_pat;
  assign cmd_pat = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ===========================================================================
  // clocking
  property p_clk_pair; ddr_clk_p != ddr_clk_n; endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clock pair not complementary");
  property p_clk_half; $rose(ddr_clk_p) && ce && !clk_stop_req && !clk_stop_ack |=> !ddr_clk_p; endproperty
  a_clk_half: assert property (p_clk_half) else $error("memory clock not at half rate");
  property p_clk_frz; clk_stop_ack && $past(clk_stop_ack) |-> $stable(ddr_clk_p) && $stable(ddr_clk_n); endproperty
  a_clk_frz: assert property (p_clk_frz) else $error("memory clock runs while stopped");
  // ===========================================================================
  // commands and data
  property p_cmd_hold; $fell(ddr_cs_n) |=> $stable(cmd_pat) && $stable(ddr_ba) && $stable(ddr_a); endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command not held a memory cycle");
  property p_wr_data; $fell(ddr_we_n) && cmd_pat == 4'h4 |-> ##2 ddr_dq_oe && ddr_dqs_oe && ddr_dqs_o == 2'h3; endproperty
  a_wr_data: assert property (p_wr_data) else $error("write not followed by data step");
  property p_rd_gate; $fell(ddr_cas_n) && cmd_pat == 4'h5 |-> ##2 strobe_gate_out [*2]; endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read not followed by strobe gate");
  property p_no_drive; strobe_gate_out |-> !ddr_dq_oe && !ddr_dqs_oe; endproperty
  a_no_drive: assert property (p_no_drive) else $error("data driven while gating reads");
  property p_rd_cap; strobe_gate_return && ddr_dqs_i != 2'h0 && ce |=> rd_valid && rd_data == $past(ddr_dq_i); endproperty
  a_rd_cap: assert property (p_rd_cap) else $error("read word not captured");
  property p_cke_fall; $fell(ddr_cke) |-> !ddr_cs_n && ddr_we_n && ddr_ras_n == ddr_cas_n; endproperty
  a_cke_fall: assert property (p_cke_fall) else $error("clock enable dropped with wrong command");
  property p_cke_rise; $rose(ddr_cke) |-> cmd_pat == 4'h7 || ddr_cs_n; endproperty
  a_cke_rise: assert property (p_cke_rise) else $error("clock enable raised without nop");
endmodule // ddrc_chk

bind ddrc_top ddrc_chk chk_u (.*);

// ===== ddrc_mem_model.sv
// far-side memory model: loops the strobe gate and returns read data
`timescale 1ns/1ps
module ddrc_mem_model #(
  parameter logic [15:0] RD_WORD = 16'hC3A5
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        strobe_gate_out,
  output logic             strobe_gate_return,
  output logic      [15:0] ddr_dq_i,
  output logic      [1:0]  ddr_dqs_i
);
  // ===========================================================================
  // board loop and read burst
  // one cycle of flight; an undriven bus shows the inverse of its last value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_gate_return <= 1'b0;
      ddr_dqs_i          <= 2'h0;
      ddr_dq_i           <= 16'h0;
    end else begin
      strobe_gate_return <= strobe_gate_out;
      ddr_dqs_i          <= strobe_gate_out ? 2'h3 : 2'h0;
      ddr_dq_i           <= strobe_gate_out ? RD_WORD : ~ddr_dq_i;
    end
  end
endmodule // ddrc_mem_model

// ===== ddrc_top_tb.sv
// testbench for the ddr command encoder
`timescale 1ns/1ps
module ddrc_top_tb;
  localparam logic [15:0] RDW  = 16'hC3A5;
  localparam logic [63:0] PATS = 64'h7771_1445_5002_23F7;
  localparam logic [15:0] FM   = 16'h0798;
  localparam logic [15:0] FV   = 16'h0508;
  localparam logic [15:0] BAM  = 16'h07F4;
  localparam logic [15:0] AM   = 16'h07E4;
  logic        core_clk, rst_n, ce, primary_pll_tick, req_valid, clk_stop_req;
  logic        req_ready, rd_valid, clk_stop_ack, ddr_clk_p, ddr_clk_n, ddr_cke;
  logic        ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_dq_oe, ddr_dqs_oe;
  logic        strobe_gate_out, strobe_gate_return;
  logic [3:0]  req_code;
  logic [2:0]  req_bank, ddr_ba;
  logic [13:0] req_addr, ddr_a;
  logic [15:0] req_wdata, rd_data, ddr_dq_o, ddr_dq_i;
  logic [1:0]  req_wmask, ddr_dm, ddr_dqs_o, ddr_dqs_i;
  int          err_total, checks_done;

  ddrc_top dut_u (.*);
  ddrc_mem_model #(.RD_WORD(RDW)) mem_u (.*);

  always #50 core_clk = ~core_clk;

  // ===========================================================================
  // helpers
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ticks run free so queued entries can leave the fifo; two edges span one bus strobe
  task send(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic [15:0] d,
            input logic [1:0] m);
    @(negedge core_clk);
    {req_code, req_bank, req_addr, req_wdata, req_wmask} = {c, b, a, d, m};
    req_valid = 1'b1;
    repeat (2) @(negedge core_clk);
    req_valid = 1'b0;
  endtask

  task wait_cs;
    int n;
    n = 0;
    while (ddr_cs_n !== 1'b0) begin
      @(negedge core_clk);
      n++;
      if (n > 80) begin
        chk("cmd_timeout", 16'h1, 16'h0);
        close_out;
      end
    end
  endtask

  // ===========================================================================
  // scenarios
  task t_reset;
    chk("rst_cmd", 16'hF, {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n});
    chk("rst_misc", 16'h11, {ddr_cke, ddr_clk_p, ddr_clk_n, ddr_dq_oe, ddr_dqs_oe, strobe_gate_out, req_ready});
  endtask

  task t_clock;
    logic p;
    p = ddr_clk_p;
    repeat (8) begin
      @(negedge core_clk);
      chk("clk_toggle", !p, ddr_clk_p);
      chk("clk_pair", !ddr_clk_p, ddr_clk_n);
      p = ddr_clk_p;
    end
    ce = 1'b0;
    p = ddr_clk_p;
    repeat (4) @(negedge core_clk);
    chk("ce_freeze", p, ddr_clk_p);
    ce = 1'b1;
  endtask

  task issue(input logic [3:0] c);
    logic [13:0] ad;
    logic [13:0] ea;
    logic [15:0] wd;
    int          n;
    ad = 14'h235B ^ {c, 10'h0};
    ad[10] = FM[c] ? !FV[c] : c[0];
    ea = ad;
    if (FM[c]) ea[10] = FV[c];
    wd = 16'hA5A0 ^ c;
    send(c, c[2:0] ^ 3'h5, ad, wd, {!c[0], c[0]});
    if (c == ddrc_pkg::CMD_DESELECT) begin
      n = 0;
      repeat (30) begin
        @(negedge core_clk);
        n += (ddr_cs_n !== 1'b1);
      end
      chk("deselect_cmd_cs", 16'h0, n);
      return;
    end
    wait_cs;
    chk("pattern", PATS[{c, 2'b00} +: 4], {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n});
    if (FM[c]) chk("a10", FV[c], ddr_a[10]);
    if (AM[c]) chk("addr", ea, ddr_a);
    if (BAM[c]) chk("bank", c[2:0] ^ 3'h5, ddr_ba);
    chk("cke", !(c == ddrc_pkg::CMD_SREF_ENTER || c == ddrc_pkg::CMD_PD_ENTER), ddr_cke);
    repeat (2) @(negedge core_clk);
    if (c inside {ddrc_pkg::CMD_WRITE, ddrc_pkg::CMD_WRITE_AP}) begin
      chk("wr_ctl", {2'h3, !c[0], c[0]}, {ddr_dq_oe, ddr_dqs_oe, ddr_dm});
      chk("wr_dq", wd, ddr_dq_o);
    end
    if (c inside {ddrc_pkg::CMD_READ, ddrc_pkg::CMD_READ_AP}) begin
      chk("gate", 16'h1, strobe_gate_out);
      n = 0;
      while (rd_valid !== 1'b1 && n < 10) begin
        @(negedge core_clk);
        n++;
      end
      chk("rd_valid", 16'h1, rd_valid);
      chk("rd_data", RDW, rd_data);
    end
    repeat (4) @(negedge core_clk);
  endtask

  task t_cmds;
    issue(ddrc_pkg::CMD_PD_EXIT);
    for (int i = 0; i < 16; i++) issue(4'(i));
  endtask

  // stopped clocks hold the queue, so it fills and then drains in order
  task t_stop;
    int   n;
    logic p;
    clk_stop_req = 1'b1;
    n = 0;
    while (clk_stop_ack !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    chk("stop_ack", 16'h1, clk_stop_ack);
    p = ddr_clk_p;
    repeat (6) @(negedge core_clk);
    chk("clk_frozen", p, ddr_clk_p);
    n = 0;
    while (req_ready === 1'b1 && n < 12) begin
      send(ddrc_pkg::CMD_NOP, 3'h0, 14'h0, 16'h0, 2'h0);
      n++;
    end
    chk("fifo_fill", ddrc_pkg::FIFO_DEPTH, n);
    clk_stop_req = 1'b0;
    n = 0;
    p = 1'b1;
    repeat (400) begin
      @(negedge core_clk);
      n += (p === 1'b1 && ddr_cs_n === 1'b0);
      p = ddr_cs_n;
    end
    chk("drained", ddrc_pkg::FIFO_DEPTH, n);
    chk("stop_clr", 16'h0, clk_stop_ack);
  endtask

  // ===========================================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    primary_pll_tick = 1'b1;
    req_valid = 1'b0;
    {req_code, req_bank, req_addr, req_wdata, req_wmask} = '0;
    clk_stop_req = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (12) @(negedge core_clk);
    t_reset;
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_clock;
    t_cmds;
    t_stop;
    close_out;
  end
endmodule // ddrc_top_tb
